// *** urb_pkg.sv ***
/*
  constants, types and helper function shared by the serial-to-radio bridge
  assumes a 50 MHz core clock; every cycle count below is derived from that rate
*/
package urb_pkg;

  localparam int unsigned URB_CLK_HZ       = 50_000_000;
  // reset low time, ready delay and blink rate in their own units
  localparam int unsigned URB_RST_MIN_NS   = 1000;
  localparam int unsigned URB_RST_MIN_CYC  = (URB_RST_MIN_NS * (URB_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned URB_READY_US     = 500;
  localparam int unsigned URB_READY_CYC    = URB_READY_US * (URB_CLK_HZ / 1_000_000);
  localparam int unsigned URB_BLINK_HZ     = 2;
  localparam int unsigned URB_BLINK_HALF   = URB_CLK_HZ / (2 * URB_BLINK_HZ);

  // serial rates and transmit power indices; rate index 6 is the factory and loader rate
  localparam logic [2:0]  URB_BAUD_IDX_DEF = 3'h6;
  localparam logic [2:0]  URB_TX_POWER_DEF = 3'h0;
  localparam logic [2:0]  URB_TX_POWER_MAX = 3'h4;
  localparam int unsigned URB_LOADER_BAUD  = 115200;

  localparam int unsigned URB_DATA_BITS    = 8;
  localparam int unsigned URB_LINE_CHARS   = 12;
  localparam logic [7:0]  URB_CHAR_CR      = 8'h0d;
  localparam logic [7:0]  URB_CHAR_LF      = 8'h0a;
  localparam logic [7:0]  URB_CHAR_ZERO    = 8'h30;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } urb_byte_type;

  typedef struct packed {
    logic [2:0] baud_idx;
    logic [2:0] pwr_idx;
  } urb_cfg_type;

  typedef enum logic [3:0] {
    URB_RX_IDLE  = 4'b0001,
    URB_RX_START = 4'b0010,
    URB_RX_DATA  = 4'b0100,
    URB_RX_STOP  = 4'b1000
  } urb_rx_state_type;

  function automatic logic [15:0] urb_div(input logic [2:0] idx);
    int unsigned baud;
    baud = 115200;
    unique case (idx)
      3'h0: baud = 4800;
      3'h1: baud = 9600;
      3'h2: baud = 14400;
      3'h3: baud = 19200;
      3'h4: baud = 38400;
      3'h5: baud = 57600;
      3'h6: baud = 115200;
      3'h7: baud = 5000000;
    endcase
    return 16'((URB_CLK_HZ + baud / 2) / baud);
  endfunction

endpackage

// *** urb_bridge.sv ***
/*
  serial-to-radio bridge: command interpreter while unlinked outside loader mode, transparent
  tunnel while linked, link indicator blinker and boot-select strap capture.
  assumes the radio side presents a byte stream with valid/ready and a
  level that says a peer is connected; all inputs are synchronous to core_clk_i
*/
`timescale 1ns/1ps

module urb_bridge #(
  parameter int unsigned BLINK_HALF_CYC = urb_pkg::URB_BLINK_HALF,
  parameter int unsigned READY_CYC      = urb_pkg::URB_READY_CYC
) (
  // clock and reset
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_n_i,
  // module pins
  input  wire logic                 boot_select_pin_i,
  input  wire logic                 host_serial_rx_pin_i,
  output logic                      host_serial_tx_pin_o,
  output logic                      link_indicator_pin_o,
  // radio side
  input  wire logic                 peer_connected_i,
  output urb_pkg::urb_byte_type     radio_tx_o,
  input  wire logic                 radio_tx_ready_i,
  input  wire urb_pkg::urb_byte_type radio_rx_i,
  output logic                      radio_rx_ready_o,
  // status and configuration
  output urb_pkg::urb_cfg_type      cfg_o,
  output logic                      loader_mode_o,
  output urb_pkg::urb_byte_type     loader_byte_o,
  output logic                      module_ready_o,
  output logic                      frame_error_o,
  output logic                      overrun_o
);
  import urb_pkg::*;

  logic               strap_taken_reg;
  logic               loader_reg;
  logic               link_up_reg;
  logic [31:0]        ready_cnt_reg;
  urb_cfg_type        cfg_reg;
  urb_rx_state_type   rx_state_reg;
  logic [15:0]        rx_cnt_reg;
  logic [3:0]         rx_bit_reg;
  logic [7:0]         rx_shift_reg;
  logic               rx_done_reg;
  logic               frame_err_reg;
  urb_byte_type       fwd_reg;
  logic               overrun_reg;
  logic [8*URB_LINE_CHARS-1:0] line_reg;
  logic [3:0]         line_len_reg;
  logic [9:0]         tx_shift_reg;
  logic [3:0]         tx_bits_reg;
  logic [15:0]        tx_cnt_reg;
  logic [31:0]        blink_cnt_reg;
  logic               led_reg;
  urb_byte_type       loader_byte_reg;

  // selection and decode
  wire logic [15:0] div_w      = loader_reg ? urb_div(URB_BAUD_IDX_DEF) : urb_div(cfg_reg.baud_idx);
  wire logic        rx_tick_w  = (rx_cnt_reg == 16'h0000);
  wire logic        tx_tick_w  = (tx_cnt_reg == 16'h0000);
  wire logic        tx_idle_w  = (tx_bits_reg == 4'h0);
  wire logic        cmd_mode_w = !link_up_reg && !loader_reg;
  wire logic        tun_mode_w = link_up_reg && !loader_reg;
  wire logic        eol_w      = (rx_shift_reg == URB_CHAR_CR) || (rx_shift_reg == URB_CHAR_LF);
  wire logic        line_end_w = rx_done_reg && cmd_mode_w && eol_w;
  wire logic [7:0]  last_ch_w  = line_reg[7:0];
  wire logic [2:0]  digit_w    = 3'(last_ch_w - URB_CHAR_ZERO);
  wire logic        is_digit_w = (last_ch_w >= URB_CHAR_ZERO) && (last_ch_w <= 8'h37);
  wire logic        cmd_pwr_w  = line_end_w && (line_len_reg == 4'h8) &&
                                 (line_reg[63:8] == "AT+PWR=") && is_digit_w &&
                                 (digit_w <= URB_TX_POWER_MAX);
  wire logic        cmd_spd_w  = line_end_w && (line_len_reg == 4'ha) &&
                                 (line_reg[79:8] == "AT+SPEED=") && is_digit_w;
  wire logic        cmd_def_w  = line_end_w && (line_len_reg == 4'ha) &&
                                 (line_reg[79:0] == "AT+DEFAULT");
  wire logic        rx_take_w  = radio_rx_i.valid && radio_rx_ready_o;
  wire logic        blink_end_w = (blink_cnt_reg >= BLINK_HALF_CYC - 1);

  assign radio_rx_ready_o     = tun_mode_w && tx_idle_w;
  assign host_serial_tx_pin_o = tx_shift_reg[0];
  assign link_indicator_pin_o = led_reg;
  assign radio_tx_o           = fwd_reg;
  assign cfg_o                = cfg_reg;
  assign loader_mode_o        = loader_reg;
  assign loader_byte_o        = loader_byte_reg;
  assign module_ready_o       = (ready_cnt_reg >= READY_CYC);
  assign frame_error_o        = frame_err_reg;
  assign overrun_o            = overrun_reg;

  // the strap is caught on the first edge after release, never under reset
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      strap_taken_reg <= 1'b0;
      loader_reg      <= 1'b0;
    end else if (!strap_taken_reg) begin
      strap_taken_reg <= 1'b1;
      loader_reg      <= boot_select_pin_i;
    end
  end

  // informs the host when the block is ready to talk
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ready_cnt_reg <= 32'h0;
    end else if (ready_cnt_reg < READY_CYC) begin
      ready_cnt_reg <= ready_cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      link_up_reg <= 1'b0;
    end else begin
      link_up_reg <= peer_connected_i && !loader_reg;
    end
  end

  // receiver: mid-bit sampling, 8N1 only
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rx_state_reg  <= URB_RX_IDLE;
      rx_cnt_reg    <= 16'h0;
      rx_bit_reg    <= 4'h0;
      rx_shift_reg  <= 8'h0;
      rx_done_reg   <= 1'b0;
      frame_err_reg <= 1'b0;
    end else begin
      rx_done_reg   <= 1'b0;
      frame_err_reg <= 1'b0;
      rx_cnt_reg    <= rx_tick_w ? 16'h0 : rx_cnt_reg - 16'h1;
      unique case (rx_state_reg)
        URB_RX_IDLE: if (!host_serial_rx_pin_i) begin
          rx_state_reg <= URB_RX_START;
          rx_cnt_reg   <= {1'b0, div_w[15:1]};
        end
        URB_RX_START: if (rx_tick_w) begin
          rx_state_reg <= host_serial_rx_pin_i ? URB_RX_IDLE : URB_RX_DATA;
          rx_cnt_reg   <= div_w - 16'h1;
          rx_bit_reg   <= 4'h0;
        end
        URB_RX_DATA: if (rx_tick_w) begin
          rx_shift_reg <= {host_serial_rx_pin_i, rx_shift_reg[7:1]};
          rx_cnt_reg   <= div_w - 16'h1;
          rx_bit_reg   <= rx_bit_reg + 4'h1;
          if (rx_bit_reg == 4'(URB_DATA_BITS - 1)) begin
            rx_state_reg <= URB_RX_STOP;
          end
        end
        URB_RX_STOP: if (rx_tick_w) begin
          rx_state_reg  <= URB_RX_IDLE;
          rx_done_reg   <= host_serial_rx_pin_i;
          frame_err_reg <= !host_serial_rx_pin_i;
        end
      endcase
    end
  end

  // one holding byte toward the radio; a byte arriving while it is full and the radio is not ready is lost
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      fwd_reg     <= '0;
      overrun_reg <= 1'b0;
    end else begin
      overrun_reg <= 1'b0;
      if (!tun_mode_w) begin
        fwd_reg.valid <= 1'b0;
      end else if (rx_done_reg && (!fwd_reg.valid || radio_tx_ready_i)) begin
        fwd_reg <= '{valid: 1'b1, data: rx_shift_reg};
      end else begin
        if (fwd_reg.valid && radio_tx_ready_i) begin
          fwd_reg.valid <= 1'b0;
        end
        overrun_reg <= rx_done_reg;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      loader_byte_reg <= '0;
    end else begin
      loader_byte_reg <= '{valid: rx_done_reg && loader_reg, data: rx_shift_reg};
    end
  end

  // command line collector; bytes in command mode never reach the radio
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || !cmd_mode_w) begin
      line_reg     <= '0;
      line_len_reg <= 4'h0;
    end else if (line_end_w) begin
      line_len_reg <= 4'h0;
    end else if (rx_done_reg) begin
      line_reg     <= {line_reg[8*URB_LINE_CHARS-9:0], rx_shift_reg};
      line_len_reg <= (line_len_reg == 4'(URB_LINE_CHARS)) ? line_len_reg : line_len_reg + 4'h1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cfg_reg <= '{baud_idx: URB_BAUD_IDX_DEF, pwr_idx: URB_TX_POWER_DEF};
    end else if (cmd_def_w) begin
      cfg_reg <= '{baud_idx: URB_BAUD_IDX_DEF, pwr_idx: URB_TX_POWER_DEF};
    end else if (cmd_pwr_w) begin
      cfg_reg.pwr_idx <= digit_w;
    end else if (cmd_spd_w) begin
      cfg_reg.baud_idx <= digit_w;
    end
  end

  // transmitter; idle line is high, frame is start, 8 data lsb first, stop
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      tx_shift_reg <= 10'h3ff;
      tx_bits_reg  <= 4'h0;
      tx_cnt_reg   <= 16'h0;
    end else if (rx_take_w) begin
      tx_shift_reg <= {1'b1, radio_rx_i.data, 1'b0};
      tx_bits_reg  <= 4'ha;
      tx_cnt_reg   <= div_w - 16'h1;
    end else if (!tx_idle_w) begin
      tx_cnt_reg <= tx_tick_w ? div_w - 16'h1 : tx_cnt_reg - 16'h1;
      if (tx_tick_w) begin
        tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
        tx_bits_reg  <= tx_bits_reg - 4'h1;
      end
    end
  end

  // link indicator: blink while unlinked, steady low once linked
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || link_up_reg) begin
      blink_cnt_reg <= 32'h0;
      led_reg       <= 1'b0;
    end else if (blink_end_w) begin
      blink_cnt_reg <= 32'h0;
      led_reg       <= !led_reg;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 32'h1;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_led_low_linked: assert property (link_up_reg |=> !link_indicator_pin_o)
    else $error("indicator not low while linked");
  a_led_toggle: assert property (!link_up_reg && !peer_connected_i && blink_end_w
    |=> link_indicator_pin_o != $past(link_indicator_pin_o))
    else $error("indicator did not toggle at half period");
  a_fwd_unchanged: assert property (tun_mode_w && rx_done_reg && !fwd_reg.valid
    |=> radio_tx_o.valid && radio_tx_o.data == $past(rx_shift_reg))
    else $error("serial byte not forwarded unchanged");
  a_cmd_not_fwd: assert property (!link_up_reg && !$past(link_up_reg) |-> !radio_tx_o.valid)
    else $error("command mode byte reached radio");
  a_pwr_update: assert property (cmd_pwr_w |=> cfg_o.pwr_idx == $past(digit_w))
    else $error("power index not stored");
  a_default_cfg: assert property (cmd_def_w
    |=> cfg_o.baud_idx == URB_BAUD_IDX_DEF && cfg_o.pwr_idx == URB_TX_POWER_DEF)
    else $error("factory default not applied");
  a_radio_to_tx: assert property (rx_take_w
    |=> !host_serial_tx_pin_o && tx_shift_reg[8:1] == $past(radio_rx_i.data))
    else $error("radio byte not started on transmit pin");
  a_tx_idle_high: assert property (tx_idle_w |-> host_serial_tx_pin_o)
    else $error("transmit line not idle high");
  a_loader_rate: assert property (loader_mode_o |-> div_w == urb_div(URB_BAUD_IDX_DEF))
    else $error("loader not at fixed rate");
  a_loader_quiet: assert property (loader_mode_o |-> !radio_tx_o.valid && !radio_rx_ready_o)
    else $error("tunnel active in loading mode");
  a_rx_frame: assert property (rx_done_reg |-> $past(rx_state_reg) == URB_RX_STOP)
    else $error("byte completed outside stop bit");

  c_tunnel_out: cover property (rx_done_reg && tun_mode_w);
  c_tunnel_in:  cover property (rx_take_w);
  c_cmd_pwr:    cover property (cmd_pwr_w);
  c_link_loss:  cover property (link_up_reg ##1 !link_up_reg);

endmodule

// *** urb_host_model.sv ***
/*
  host controller model on the serial link: sends 8N1 frames and decodes frames
  from the module. assumes div_i holds core clocks per bit for the current rate
*/
`timescale 1ns/1ps

module urb_host_model (
  // clock and rate
  input  wire logic        core_clk_i,
  input  wire logic [15:0] div_i,
  // serial wires, host view
  input  wire logic        serial_in_i,
  output logic             serial_out_o
);
  logic [7:0] got_byte;
  int         got_count;

  initial begin
    serial_out_o = 1'b1;
    got_byte     = 8'h00;
    got_count    = 0;
  end

  // a low stop bit is held just past the receiver's sample point, then the line
  // idles; a good frame leaves the line high so the next call starts cleanly
  task automatic send_byte(input logic [7:0] b, input logic stop_bit);
    logic [8:0] frame;
    frame = {b, 1'b0};
    for (int i = 0; i < 9; i++) begin
      serial_out_o <= frame[i];
      repeat (div_i) @(posedge core_clk_i);
    end
    serial_out_o <= stop_bit;
    repeat (stop_bit ? div_i : div_i / 2 + 2) @(posedge core_clk_i);
    if (!stop_bit) begin
      serial_out_o <= 1'b1;
      repeat (2 * div_i) @(posedge core_clk_i);
    end
  endtask

  always begin
    @(negedge serial_in_i);
    repeat (div_i / 2) @(posedge core_clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (div_i) @(posedge core_clk_i);
      got_byte[i] = serial_in_i;
    end
    repeat (div_i) @(posedge core_clk_i);
    got_count++;
  end
endmodule

// *** tb_urb_bridge.sv ***
/*
  self-checking bench for the serial-to-radio bridge: modes, indicator, tunnel
  and loader. assumes the host model file is compiled first
*/
`timescale 1ns/1ps

module tb_urb_bridge;
  import urb_pkg::*;
  localparam int unsigned BLINK    = 20;
  localparam int unsigned READY    = 10;
  localparam logic [15:0] DIV_DEF  = 16'h01b2;
  localparam logic [15:0] DIV_FAST = 16'h000a;
  logic         core_clk_i = 1'b0;
  logic         rst_n_i    = 1'b0;
  logic         boot_sel   = 1'b0;
  logic         peer       = 1'b0;
  logic         rtx_ready  = 1'b1;
  logic [15:0]  host_div   = DIV_DEF;
  urb_byte_type radio_rx   = '0;
  urb_byte_type radio_tx, loader_byte;
  urb_cfg_type  cfg;
  logic         h2m, m2h, ind, loader, ready, ferr, ovr, rrx_ready;
  int           n_mismatch, checks_done, ferr_count, lb_count, ovr_count;
  logic [7:0]   lb_data;
  logic [7:0]   rtx_q[$];

  urb_bridge #(.BLINK_HALF_CYC(BLINK), .READY_CYC(READY)) dut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .boot_select_pin_i(boot_sel),
    .host_serial_rx_pin_i(h2m), .host_serial_tx_pin_o(m2h), .link_indicator_pin_o(ind),
    .peer_connected_i(peer), .radio_tx_o(radio_tx), .radio_tx_ready_i(rtx_ready),
    .radio_rx_i(radio_rx), .radio_rx_ready_o(rrx_ready), .cfg_o(cfg),
    .loader_mode_o(loader), .loader_byte_o(loader_byte), .module_ready_o(ready),
    .frame_error_o(ferr), .overrun_o(ovr));
  urb_host_model host (.core_clk_i(core_clk_i), .div_i(host_div), .serial_in_i(m2h),
    .serial_out_o(h2m));

  initial begin
    forever #10 core_clk_i = ~core_clk_i;
  end

  always @(posedge core_clk_i) begin
    if (radio_tx.valid === 1'b1 && rtx_ready) rtx_q.push_back(radio_tx.data);
    if (ferr === 1'b1) ferr_count++;
    if (ovr === 1'b1) ovr_count++;
    if (loader_byte.valid === 1'b1) begin
      lb_count++;
      lb_data = loader_byte.data;
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (n_mismatch == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic send_line(input string s);
    for (int i = 0; i < s.len(); i++) host.send_byte(s[i], 1'b1);
    host.send_byte(URB_CHAR_CR, 1'b1);
    repeat (4) @(posedge core_clk_i);
  endtask

  // exactly one toggle falls in any run of BLINK edges
  task automatic blink_check();
    logic a;
    a = ind;
    repeat (BLINK) @(posedge core_clk_i);
    check({7'h00, ind}, {7'h00, ~a});
  endtask

  task automatic t_reset();
    repeat (3) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(posedge core_clk_i);
    @(posedge core_clk_i);
    check({m2h, ind, loader, ready, 4'h0}, 8'h80);
    check({2'h0, cfg}, 8'h30);
    repeat (READY + 2) @(posedge core_clk_i);
    check({7'h00, ready}, 8'h01);
  endtask

  task automatic t_command();
    blink_check();
    send_line("AT+SPEED=7");
    host_div <= DIV_FAST;
    repeat (20) @(posedge core_clk_i);
    send_line("AT+PWR=3");
    check({2'h0, cfg}, 8'h3b);
    check(8'(rtx_q.size()), 8'h00);
  endtask

  task automatic t_tunnel();
    string s;
    s = "AT+PWR=1";
    peer <= 1'b1;
    repeat (5) @(posedge core_clk_i);
    check({7'h00, ind}, 8'h00);
    send_line(s);
    check(8'(rtx_q.size()), 8'h09);
    for (int i = 0; i < 8; i++) check(rtx_q[i], s[i]);
    check(rtx_q[8], URB_CHAR_CR);
    check({2'h0, cfg}, 8'h3b);
    check({7'h00, ind}, 8'h00);
    radio_rx <= '{valid: 1'b1, data: 8'ha5};
    for (int i = 0; i < 50; i++) begin
      @(posedge core_clk_i);
      if (rrx_ready === 1'b1) break;
    end
    radio_rx <= '0;
    for (int i = 0; i < 200 && host.got_count == 0; i++) @(posedge core_clk_i);
    check(host.got_byte, 8'ha5);
  endtask

  // a second byte while the radio stalls is dropped and flagged
  task automatic t_overrun();
    rtx_ready <= 1'b0;
    host.send_byte(8'h11, 1'b1);
    host.send_byte(8'h22, 1'b1);
    rtx_ready <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    check(8'(ovr_count), 8'h01);
    check(8'(rtx_q.size()), 8'h0a);
    check(rtx_q[9], 8'h11);
  endtask

  task automatic t_unlink();
    peer <= 1'b0;
    rtx_q.delete();
    repeat (3) @(posedge core_clk_i);
    blink_check();
    host.send_byte(8'h55, 1'b0);
    check(8'(ferr_count), 8'h01);
    send_line("AT+DEFAULT");
    check({2'h0, cfg}, 8'h30);
    check(8'(rtx_q.size()), 8'h00);
    host_div <= DIV_DEF;
  endtask

  task automatic t_loader();
    rst_n_i  <= 1'b0;
    boot_sel <= 1'b1;
    repeat (50) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    check({7'h00, loader}, 8'h01);
    host.send_byte(8'h5a, 1'b1);
    repeat (4) @(posedge core_clk_i);
    check(8'(lb_count), 8'h01);
    check(lb_data, 8'h5a);
    check(8'(rtx_q.size()), 8'h00);
    rst_n_i  <= 1'b0;
    boot_sel <= 1'b0;
    repeat (50) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    check({7'h00, loader}, 8'h00);
  endtask

  initial begin
    repeat (90000) @(posedge core_clk_i);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    t_reset();
    t_command();
    t_tunnel();
    t_overrun();
    t_unlink();
    t_loader();
    tally_and_finish();
  end
endmodule
